/* File: core/cmr_defs.svh */
/*
 * Register offsets, write masks, reset values and timing counts of the
 * codec control register bank.
 * Assumes it is included by bare name after the types package.
 */
`ifndef CMR_DEFS_SVH
`define CMR_DEFS_SVH

// ----------------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------------
`define CMR_ADDR_IFACE_CLK 7'h04
`define CMR_ADDR_RATE_CLK 7'h05
`define CMR_ADDR_TIMER 7'h06
`define CMR_ADDR_ALC_FIRST 7'h07
`define CMR_ADDR_REC_REF 7'h08
`define CMR_ADDR_LEFT_IN 7'h09
`define CMR_ADDR_LEFT_OUT 7'h0a
`define CMR_ADDR_ALC_THIRD 7'h0b
`define CMR_ADDR_RIGHT_IN 7'h0c
`define CMR_ADDR_ALC_VOL 7'h0d
`define CMR_ADDR_PLAY_MODE 7'h0e
`define CMR_ADDR_IN_LINK 7'h0f
`define CMR_ADDR_ADC_SEL 7'h10
`define CMR_ADDR_FILT 7'h11
`define CMR_ADDR_RIGHT_OUT 7'h25

// ----------------------------------------------------------------------
// Writable bits (fixed-zero positions are cleared)
// ----------------------------------------------------------------------
`define CMR_MASK_IFACE_CLK 8'hfb
`define CMR_MASK_RATE_CLK 8'he7
`define CMR_MASK_TIMER 8'h7f
`define CMR_MASK_FULL 8'hff
`define CMR_MASK_IN_LINK 8'h08
`define CMR_MASK_ADC_SEL 8'h1f
`define CMR_MASK_FILT 8'hfd

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CMR_RST_IFACE_CLK 8'h02
`define CMR_RST_ZERO 8'h00
`define CMR_RST_IN_VOL 8'he1
`define CMR_RST_OUT_VOL 8'h91
`define CMR_RST_ALC_THIRD 8'h28
`define CMR_RST_PLAY_MODE 8'h11
`define CMR_RST_IN_LINK 8'h08
`define CMR_RST_FILT 8'h01

// ----------------------------------------------------------------------
// Field positions and timing
// ----------------------------------------------------------------------
`define CMR_BIT_IN_LINK 3
`define CMR_BIT_OUT_LINK 4
`define CMR_BIT_READ_EN 7
`define CMR_ZC_TIMEOUT_BASE 11'h080

`endif

/* File: core/cmr_pkg.sv */
/*
 * Types of the codec control register bank.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package cmr_pkg;

  // Decoded configuration handed to the audio datapath
  typedef struct packed {
    logic [1:0] serial_format_sel;
    logic bit_clock_out_rate;
    logic [3:0] pll_ref_sel;
    logic [3:0] fs_sel;
    logic [3:0] master_clk_in_sel;
    logic [1:0] master_clk_out_rate;
    logic [2:0] recovery_wait_sel;
    logic [1:0] zero_cross_timeout_sel;
    logic [1:0] fast_recovery_speed;
    logic limiter_zc_disable;
    logic record_agc_en;
    logic playback_agc_en;
    logic fast_limit_en;
    logic [1:0] limiter_threshold;
    logic [1:0] recovery_gain_step;
    logic [1:0] limiter_atten_step;
    logic [7:0] record_recovery_ref;
    logic [5:0] playback_recovery_ref;
    logic soft_mute;
    logic dac_from_adc;
    logic [1:0] out_coarse_atten;
    logic [1:0] deemph_sel;
    logic left_in_pin_sel;
    logic right_in_pin_sel;
    logic left_diff_in;
    logic right_diff_in;
    logic adc_right_power;
    logic [1:0] filter_gain_sel;
    logic lpf_en;
    logic hpf_en;
    logic gain_comp_eq_bypass;
    logic stereo_emph_mute;
    logic adc_highpass_en;
  } cmr_cfg_t;

  // Applied channel volumes
  typedef struct packed {
    logic [7:0] left;
    logic [7:0] right;
  } cmr_vol_pair_t;

endpackage : cmr_pkg

/* File: core/cmr_regs.sv */
/*
 * Control register bank of a stereo audio codec: interface, clocking,
 * Alc_current_volume, routing and filter enables, with zero-crossing gated
 * application of input gain changes.
 * Assumes a serial control port outside that turns host frames into
 * single-cycle write and read strobes on clk_i.
 */
// Overview of operation
// RULE1 - Audio format field resets to 10, left-justified.
// RULE2 - PLL reference select resets to 0000, frame clock pin.
// RULE3 - Rate field means sample rate with PLL, master clock rate otherwise.
// RULE4 - Master clock output rate field resets to 00, 256 fs.
// RULE5 - Recovery wait field resets to 000, 128 sample periods.
// RULE6 - Host and recovery gain changes apply at zero crossing or timeout.
// RULE7 - Fast recovery speed field resets to 00, four times.
// RULE8 - Limiter zero-cross disable at 0 waits for crossing; at 1 does not.
// RULE9 - Separate record and playback ALC enables, both reset off.
// RULE10 - Fast limit over full scale changes volume at once, else waits.
// RULE11 - Record recovery reference resets to e1, 0.375 dB steps.
// RULE12 - Both input volumes reset to e1, +30 dB.
// RULE13 - Both output volumes reset to 91, 0 dB.
// RULE14 - Playback recovery reference resets to 28, +6 dB.
// RULE15 - Alc_current_volume register is read-only and shows live ALC gain.
// RULE16 - Output link set: left output volume drives both channels.
// RULE17 - Input link set: left input volume drives both channels.
// RULE18 - Soft mute bit set mutes the DAC outputs softly.
// RULE19 - Loopback bit feeds DAC from ADC data instead of serial input.
// RULE20 - Coarse output attenuation, four 6 dB steps, resets to 0 dB.
// RULE21 - Per-channel input pin and single or differential selects.
// RULE22 - Emphasis disabled mutes; equalizer disabled passes through.
// RULE23 - Power-down pin low returns every register to reset; Alc_current_volume keeps sampling live gain.
// RULE24 - Writes to the Alc_current_volume register have no effect.
// RULE25 - Host writes zero into every unused bit; the bench writes ff to registers with fixed-zero bits.
// RULE26 - Fixed-zero bits read zero and ignore writes.
// RULE27 - Linked right registers keep their values for later unlinking.
`timescale 1ns/100ps
`default_nettype none
`include "cmr_defs.svh"

module cmr_regs
  import cmr_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic power_down_pin_n_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [6:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic pll_mode_i,
  input wire logic [7:0] live_agc_gain_i,
  input wire logic sample_tick_i,
  input wire logic zero_cross_i,
  input wire logic recovery_step_i,
  input wire logic limiter_step_i,
  input wire logic over_full_scale_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  output cmr_cfg_t cfg_o,
  output cmr_vol_pair_t in_vol_o,
  output cmr_vol_pair_t out_vol_o,
  output logic gain_update_o
);

  // ----------------------------------------------------------------------
  // Register table
  // ----------------------------------------------------------------------
  localparam int NUM_REGS = 14;
  localparam logic [6:0] REG_ADDR [NUM_REGS] = '{
    `CMR_ADDR_IFACE_CLK, `CMR_ADDR_RATE_CLK, `CMR_ADDR_TIMER, `CMR_ADDR_ALC_FIRST,
    `CMR_ADDR_REC_REF, `CMR_ADDR_LEFT_IN, `CMR_ADDR_LEFT_OUT, `CMR_ADDR_ALC_THIRD,
    `CMR_ADDR_RIGHT_IN, `CMR_ADDR_PLAY_MODE, `CMR_ADDR_IN_LINK, `CMR_ADDR_ADC_SEL,
    `CMR_ADDR_FILT, `CMR_ADDR_RIGHT_OUT};
  localparam logic [7:0] REG_MASK [NUM_REGS] = '{
    `CMR_MASK_IFACE_CLK, `CMR_MASK_RATE_CLK, `CMR_MASK_TIMER, `CMR_MASK_FULL,
    `CMR_MASK_FULL, `CMR_MASK_FULL, `CMR_MASK_FULL, `CMR_MASK_FULL,
    `CMR_MASK_FULL, `CMR_MASK_FULL, `CMR_MASK_IN_LINK, `CMR_MASK_ADC_SEL,
    `CMR_MASK_FILT, `CMR_MASK_FULL};
  localparam logic [7:0] REG_RST [NUM_REGS] = '{
    `CMR_RST_IFACE_CLK, `CMR_RST_ZERO, `CMR_RST_ZERO, `CMR_RST_ZERO,
    `CMR_RST_IN_VOL, `CMR_RST_IN_VOL, `CMR_RST_OUT_VOL, `CMR_RST_ALC_THIRD,
    `CMR_RST_IN_VOL, `CMR_RST_PLAY_MODE, `CMR_RST_IN_LINK, `CMR_RST_ZERO,
    `CMR_RST_FILT, `CMR_RST_OUT_VOL};

  logic [7:0] regs [NUM_REGS];
  logic [7:0] alc_current_volume;

  // Slot names for readability
  logic [7:0] interface_clock_mode, rate_and_clock_out_select, alc_timer_select;
  logic [7:0] alc_control_first, record_alc_reference, left_input_volume;
  logic [7:0] left_output_volume, alc_control_third, right_input_volume;
  logic [7:0] playback_mode_control, input_volume_link, adc_right_power_input_select;
  logic [7:0] filter_enable_first, right_output_volume;

  assign interface_clock_mode = regs[0];
  assign rate_and_clock_out_select = regs[1];
  assign alc_timer_select = regs[2];
  assign alc_control_first = regs[3];
  assign record_alc_reference = regs[4];
  assign left_input_volume = regs[5];
  assign left_output_volume = regs[6];
  assign alc_control_third = regs[7];
  assign right_input_volume = regs[8];
  assign playback_mode_control = regs[9];
  assign input_volume_link = regs[10];
  assign adc_right_power_input_select = regs[11];
  assign filter_enable_first = regs[12];
  assign right_output_volume = regs[13];

  logic in_vol_link, out_vol_link;
  assign in_vol_link = input_volume_link[`CMR_BIT_IN_LINK];
  assign out_vol_link = playback_mode_control[`CMR_BIT_OUT_LINK];

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  // The read-only slot is absent from the table, so its writes fall away
  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g++) begin : g_reg
      always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          regs[g] <= REG_RST[g];
        end else if (!power_down_pin_n_i) begin
          regs[g] <= REG_RST[g]; // [RULE23] [RULE1] [RULE2] [RULE4] [RULE5] [RULE7]
        end else if (wr_en_i && addr_i == REG_ADDR[g]) begin
          regs[g] <= wdata_i & REG_MASK[g]; // [RULE26] [RULE24] [RULE27]
        end
      end
    end
  endgenerate

  // Live gain sampled every cycle; reset clears it to 00
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      alc_current_volume <= 8'h00;
    end else begin
      alc_current_volume <= live_agc_gain_i; // [RULE15]
    end
  end

  // ----------------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------------
  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = 8'h00;
    if (addr_i == `CMR_ADDR_ALC_VOL) begin
      next_rdata = alc_current_volume; // [RULE15]
    end
    for (int i = 0; i < NUM_REGS; i++) begin
      if (addr_i == REG_ADDR[i]) begin
        next_rdata = regs[i];
      end
    end
    // Reads are only served once software has turned the read path on
    if (!playback_mode_control[`CMR_BIT_READ_EN]) begin
      next_rdata = 8'h00;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o <= 8'h00;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= rd_en_i;
      if (rd_en_i) begin
        rdata_o <= next_rdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Decoded configuration
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cfg_o <= '0;
    end else begin
      cfg_o.serial_format_sel <= interface_clock_mode[1:0]; // [RULE1]
      cfg_o.bit_clock_out_rate <= interface_clock_mode[3];
      cfg_o.pll_ref_sel <= interface_clock_mode[7:4]; // [RULE2]
      cfg_o.fs_sel <= pll_mode_i ?
        {rate_and_clock_out_select[5], rate_and_clock_out_select[2:0]} : 4'h0; // [RULE3]
      cfg_o.master_clk_in_sel <= pll_mode_i ? 4'h0 :
        {rate_and_clock_out_select[5], rate_and_clock_out_select[2:0]}; // [RULE3]
      cfg_o.master_clk_out_rate <= rate_and_clock_out_select[7:6]; // [RULE4]
      cfg_o.recovery_wait_sel <= {alc_timer_select[6], alc_timer_select[3:2]}; // [RULE5]
      cfg_o.zero_cross_timeout_sel <= alc_timer_select[5:4];
      cfg_o.fast_recovery_speed <= alc_timer_select[1:0]; // [RULE7]
      cfg_o.limiter_zc_disable <= alc_control_first[4];
      cfg_o.record_agc_en <= alc_control_first[5]; // [RULE9]
      cfg_o.playback_agc_en <= alc_control_first[6]; // [RULE9]
      cfg_o.fast_limit_en <= alc_control_first[7];
      cfg_o.limiter_threshold <= {alc_control_third[6], alc_control_first[0]};
      cfg_o.recovery_gain_step <= {alc_control_third[7], alc_control_first[1]};
      cfg_o.limiter_atten_step <= alc_control_first[3:2];
      cfg_o.record_recovery_ref <= record_alc_reference; // [RULE11]
      cfg_o.playback_recovery_ref <= alc_control_third[5:0]; // [RULE14]
      cfg_o.soft_mute <= playback_mode_control[5]; // [RULE18]
      cfg_o.dac_from_adc <= playback_mode_control[6]; // [RULE19]
      cfg_o.out_coarse_atten <= playback_mode_control[3:2]; // [RULE20]
      cfg_o.deemph_sel <= playback_mode_control[1:0];
      cfg_o.left_in_pin_sel <= adc_right_power_input_select[1]; // [RULE21]
      cfg_o.right_in_pin_sel <= adc_right_power_input_select[2]; // [RULE21]
      cfg_o.left_diff_in <= adc_right_power_input_select[3]; // [RULE21]
      cfg_o.right_diff_in <= adc_right_power_input_select[4]; // [RULE21]
      cfg_o.adc_right_power <= adc_right_power_input_select[0];
      cfg_o.filter_gain_sel <= filter_enable_first[7:6];
      cfg_o.lpf_en <= filter_enable_first[5];
      cfg_o.hpf_en <= filter_enable_first[4];
      cfg_o.gain_comp_eq_bypass <= ~filter_enable_first[3]; // [RULE22]
      cfg_o.stereo_emph_mute <= ~filter_enable_first[2]; // [RULE22]
      cfg_o.adc_highpass_en <= filter_enable_first[0];
    end
  end

  // Output volumes take effect directly
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      out_vol_o <= {`CMR_RST_OUT_VOL, `CMR_RST_OUT_VOL};
    end else begin
      out_vol_o.left <= left_output_volume; // [RULE13]
      out_vol_o.right <= out_vol_link ? left_output_volume : right_output_volume; // [RULE16]
    end
  end

  // ----------------------------------------------------------------------
  // Zero-crossing gated gain application
  // ----------------------------------------------------------------------
  logic host_vol_write;
  logic gain_pending, lim_pending;
  logic [10:0] zc_count;
  logic [10:0] zc_limit;
  logic zc_expired, apply_now, lim_immediate;

  assign host_vol_write = wr_en_i && power_down_pin_n_i &&
    (addr_i == `CMR_ADDR_LEFT_IN || addr_i == `CMR_ADDR_RIGHT_IN ||
     addr_i == `CMR_ADDR_IN_LINK);
  assign zc_limit = `CMR_ZC_TIMEOUT_BASE << alc_timer_select[5:4];
  assign zc_expired = sample_tick_i && (zc_count == zc_limit - 11'h001);
  assign apply_now = zero_cross_i || zc_expired; // [RULE6]
  // Immediate step when over full scale in fast mode, or crossing detection is off
  assign lim_immediate = limiter_step_i &&
    ((alc_control_first[7] && over_full_scale_i) || alc_control_first[4]); // [RULE10] [RULE8]

  // Timeout counts sample periods while anything waits
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      zc_count <= 11'h000;
    end else if (!(gain_pending || lim_pending) || apply_now) begin
      zc_count <= 11'h000;
    end else if (sample_tick_i) begin
      zc_count <= zc_count + 11'h001;
    end
  end

  // A new request in the applying cycle stays pending
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gain_pending <= 1'b0;
    end else if (host_vol_write || recovery_step_i) begin
      gain_pending <= 1'b1; // [RULE6]
    end else if (apply_now) begin
      gain_pending <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lim_pending <= 1'b0;
    end else if (limiter_step_i && !lim_immediate) begin
      lim_pending <= 1'b1; // [RULE8] [RULE10]
    end else if (apply_now) begin
      lim_pending <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gain_update_o <= 1'b0;
    end else begin
      gain_update_o <= lim_immediate || ((gain_pending || lim_pending) && apply_now);
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      in_vol_o <= {`CMR_RST_IN_VOL, `CMR_RST_IN_VOL};
    end else if (!power_down_pin_n_i) begin
      in_vol_o <= {`CMR_RST_IN_VOL, `CMR_RST_IN_VOL}; // [RULE12]
    end else if (gain_pending && apply_now) begin
      in_vol_o.left <= left_input_volume; // [RULE6]
      in_vol_o.right <= in_vol_link ? left_input_volume : right_input_volume; // [RULE17]
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_pdn_defaults;
    @(posedge clk_i) disable iff (!reset_n_i)
    !power_down_pin_n_i |=> interface_clock_mode == 8'h02 && alc_timer_select == 8'h00 &&
      playback_mode_control == 8'h11 && right_output_volume == 8'h91;
  endproperty
  a_pdn_defaults: assert property (p_pdn_defaults) else $error("defaults lost"); // [RULE23]

  property p_format_out;
    @(posedge clk_i) disable iff (!reset_n_i)
    !power_down_pin_n_i |=> ##1 cfg_o.serial_format_sel == 2'b10 &&
      cfg_o.pll_ref_sel == 4'h0 && cfg_o.master_clk_out_rate == 2'b00;
  endproperty
  a_format_out: assert property (p_format_out) else $error("bad reset format"); // [RULE1]

  property p_ro_write;
    @(posedge clk_i) disable iff (!reset_n_i)
    wr_en_i && power_down_pin_n_i && addr_i == `CMR_ADDR_ALC_VOL |=>
      $stable(left_input_volume) && $stable(record_alc_reference) &&
      $stable(right_output_volume);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only write had effect"); // [RULE24]

  property p_reserved_zero;
    @(posedge clk_i) disable iff (!reset_n_i)
    (input_volume_link & 8'hf7) == 8'h00 && interface_clock_mode[2] == 1'b0 &&
      filter_enable_first[1] == 1'b0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set"); // [RULE26]

  property p_out_link;
    @(posedge clk_i) disable iff (!reset_n_i)
    ##1 out_vol_o.right == ($past(out_vol_link) ? $past(left_output_volume) :
      $past(right_output_volume));
  endproperty
  a_out_link: assert property (p_out_link) else $error("right output volume wrong"); // [RULE16]

  property p_link_keeps_right;
    @(posedge clk_i) disable iff (!reset_n_i)
    wr_en_i && power_down_pin_n_i && addr_i == `CMR_ADDR_LEFT_IN |=> $stable(right_input_volume);
  endproperty
  a_link_keeps_right: assert property (p_link_keeps_right) else $error("right copied"); // [RULE27]

  property p_zc_apply;
    @(posedge clk_i) disable iff (!reset_n_i)
    gain_pending && apply_now && power_down_pin_n_i |=>
      in_vol_o.left == $past(left_input_volume) &&
      in_vol_o.right == ($past(in_vol_link) ? $past(left_input_volume) :
      $past(right_input_volume));
  endproperty
  a_zc_apply: assert property (p_zc_apply) else $error("gain not applied at crossing"); // [RULE6]

  property p_no_early_apply;
    @(posedge clk_i) disable iff (!reset_n_i)
    power_down_pin_n_i && !apply_now |=> $stable(in_vol_o);
  endproperty
  a_no_early_apply: assert property (p_no_early_apply) else $error("gain moved early"); // [RULE6]

  property p_fast_limit;
    @(posedge clk_i) disable iff (!reset_n_i)
    limiter_step_i && alc_control_first[7] && over_full_scale_i |=> gain_update_o ##1 1'b1;
  endproperty
  a_fast_limit: assert property (p_fast_limit) else $error("fast limit not immediate"); // [RULE10]

  property p_limiter_waits;
    @(posedge clk_i) disable iff (!reset_n_i)
    limiter_step_i && !lim_immediate |=> lim_pending || gain_update_o;
  endproperty
  a_limiter_waits: assert property (p_limiter_waits) else $error("limiter step lost"); // [RULE8]

  property p_live_read;
    @(posedge clk_i) disable iff (!reset_n_i)
    rd_en_i && addr_i == `CMR_ADDR_ALC_VOL && playback_mode_control[`CMR_BIT_READ_EN] |=>
      rvalid_o && rdata_o == $past(alc_current_volume);
  endproperty
  a_live_read: assert property (p_live_read) else $error("bad live volume read"); // [RULE15]

  c_zc_apply: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    gain_pending && zero_cross_i);
  c_timeout: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    gain_pending && zc_expired);
  c_fast: cover property (@(posedge clk_i) disable iff (!reset_n_i) lim_immediate);
  c_unlink: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    $fell(out_vol_link));

endmodule : cmr_regs

`default_nettype wire

/* File: verif/cmr_host_model.sv */
/*
 * Host model: drives write and read strobes of the register bank.
 * Assumes the bank samples strobes on rising edges of clk_i.
 */
`timescale 1ns/100ps
`default_nettype none
module cmr_host_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i,
  output logic wr_en_o,
  output logic rd_en_o,
  output logic [6:0] addr_o,
  output logic [7:0] wdata_o
);
  initial begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    addr_o = 7'h7f;
    wdata_o = 8'h00;
  end
  // ----------------------------------------------------------------
  // Transfers
  // ----------------------------------------------------------------
  // One byte per strobe; released bus shows inverted values, not stale ones
  task automatic write_reg(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #2;
    addr_o = a;
    wdata_o = d; // Unused bits left to caller
    wr_en_o = 1'b1;
    @(posedge clk_i);
    #2;
    wr_en_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask : write_reg
  task automatic read_reg(input logic [6:0] a, output logic [7:0] d, output logic v);
    @(posedge clk_i);
    #2;
    addr_o = a;
    rd_en_o = 1'b1;
    @(posedge clk_i);
    #2;
    rd_en_o = 1'b0;
    addr_o = ~a;
    d = rdata_i;
    v = rvalid_i;
  endtask : read_reg
endmodule : cmr_host_model
`default_nettype wire

/* File: verif/cmr_regs_test.sv */
/*
 * Self-checking bench of the codec control register bank.
 * Assumes cmr_regs, cmr_pkg and the host model are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
module cmr_regs_test;
  import cmr_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic power_down_pin_n_i = 1'b1;
  logic pll_mode_i = 1'b1;
  logic [7:0] live_agc_gain_i = 8'h3c;
  logic sample_tick_i = 1'b0, zero_cross_i = 1'b0, recovery_step_i = 1'b0;
  logic limiter_step_i = 1'b0, over_full_scale_i = 1'b0;
  logic wr_en_i, rd_en_i, rvalid_o, gain_update_o, rv;
  logic [6:0] addr_i;
  logic [7:0] wdata_i, rdata_o, rd;
  cmr_cfg_t cfg_o;
  cmr_vol_pair_t in_vol_o, out_vol_o;
  int bad_count = 0, comparisons = 0, cycles = 0;
  logic [6:0] ra [14] = '{7'h04, 7'h05, 7'h06, 7'h07, 7'h08, 7'h09, 7'h0a, 7'h0b, 7'h0c,
    7'h0e, 7'h0f, 7'h10, 7'h11, 7'h25};
  logic [7:0] rx [14] = '{8'h02, 8'h00, 8'h00, 8'h00, 8'he1, 8'he1, 8'h91, 8'h28, 8'he1,
    8'h91, 8'h08, 8'h00, 8'h01, 8'h91};
  logic [6:0] ma [7] = '{7'h04, 7'h05, 7'h06, 7'h07, 7'h0f, 7'h10, 7'h11};
  logic [7:0] mx [7] = '{8'hfb, 8'he7, 8'h7f, 8'hff, 8'h08, 8'h1f, 8'hfd};

  cmr_regs DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .power_down_pin_n_i(power_down_pin_n_i),
    .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .pll_mode_i(pll_mode_i), .live_agc_gain_i(live_agc_gain_i), .sample_tick_i(sample_tick_i),
    .zero_cross_i(zero_cross_i), .recovery_step_i(recovery_step_i),
    .limiter_step_i(limiter_step_i), .over_full_scale_i(over_full_scale_i), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .cfg_o(cfg_o), .in_vol_o(in_vol_o), .out_vol_o(out_vol_o),
    .gain_update_o(gain_update_o));
  cmr_host_model host (.clk_i(clk_i), .rdata_i(rdata_o), .rvalid_i(rvalid_o),
    .wr_en_o(wr_en_i), .rd_en_o(rd_en_i), .addr_o(addr_i), .wdata_o(wdata_i));

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  // Ceiling well above the longest scenario
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      finish_test();
    end
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic finish_test();
    if (bad_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask : cyc
  task automatic w(input logic [6:0] a, input logic [7:0] d);
    host.write_reg(a, d);
    cyc(1);
  endtask : w
  task automatic r(input logic [6:0] a, input logic [7:0] e);
    host.read_reg(a, rd, rv);
    chk("read", {7'h00, rv, rd}, {7'h00, rv, e});
    chk("rvalid", {15'h0000, rv}, 16'h0001);
  endtask : r
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask : pulse
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    cyc(5);
    reset_n_i = 1'b1;
    cyc(2);
    chk("fmt", cfg_o.serial_format_sel, 2'b10);
    chk("clk", {cfg_o.pll_ref_sel, cfg_o.master_clk_out_rate}, 0);
    chk("tim", {cfg_o.recovery_wait_sel, cfg_o.zero_cross_timeout_sel}, 0);
    chk("alc", {cfg_o.fast_recovery_speed, cfg_o.limiter_zc_disable, cfg_o.record_agc_en,
      cfg_o.playback_agc_en, cfg_o.fast_limit_en}, 0);
    chk("ref", {cfg_o.record_recovery_ref, 2'b00, cfg_o.playback_recovery_ref}, 16'he128);
    chk("play", {cfg_o.soft_mute, cfg_o.dac_from_adc, cfg_o.out_coarse_atten}, 0);
    chk("adc", {cfg_o.left_in_pin_sel, cfg_o.right_in_pin_sel, cfg_o.left_diff_in,
      cfg_o.right_diff_in}, 0);
    chk("filt", {cfg_o.stereo_emph_mute, cfg_o.gain_comp_eq_bypass}, 2'b11);
    chk("in_vol", in_vol_o, 16'he1e1);
    chk("out_vol", out_vol_o, 16'h9191);
    r(7'h08, 8'h00); // Read function still off
    w(7'h0e, 8'h91);
    foreach (ra[i]) r(ra[i], rx[i]);
    w(7'h05, 8'h25);
    chk("rate_pll", {cfg_o.fs_sel, cfg_o.master_clk_in_sel}, 8'hd0);
    pll_mode_i = 1'b0;
    cyc(2);
    chk("rate_ext", {cfg_o.fs_sel, cfg_o.master_clk_in_sel}, 8'h0d);
    w(7'h07, 8'hf0);
    chk("alc_on", {cfg_o.fast_limit_en, cfg_o.limiter_zc_disable, cfg_o.record_agc_en,
      cfg_o.playback_agc_en}, 4'hf);
    w(7'h0e, 8'hfd);
    chk("play_on", {cfg_o.soft_mute, cfg_o.dac_from_adc, cfg_o.out_coarse_atten}, 4'hf);
    w(7'h10, 8'h1e);
    chk("adc_on", {cfg_o.left_in_pin_sel, cfg_o.right_in_pin_sel, cfg_o.left_diff_in,
      cfg_o.right_diff_in}, 4'hf);
    w(7'h11, 8'h0c);
    chk("filt_on", {cfg_o.stereo_emph_mute, cfg_o.gain_comp_eq_bypass}, 0);
    w(7'h0d, 8'h55);
    r(7'h0d, 8'h3c);
    w(7'h0a, 8'h40);
    w(7'h25, 8'h20);
    chk("out_link", out_vol_o, 16'h4040);
    r(7'h25, 8'h20);
    w(7'h0e, 8'hed);
    chk("out_split", out_vol_o, 16'h4020);
    w(7'h07, 8'h80);
    w(7'h09, 8'h30);
    w(7'h0c, 8'h44);
    cyc(3);
    chk("in_wait", in_vol_o, 16'he1e1);
    pulse(zero_cross_i);
    chk("in_zc", {gain_update_o, in_vol_o}, 17'h13030);
    w(7'h0f, 8'h00);
    repeat (129) begin
      pulse(sample_tick_i);
      cyc(1);
    end
    chk("in_tmo", in_vol_o, 16'h3044);
    over_full_scale_i = 1'b1;
    pulse(limiter_step_i);
    chk("fast_lim", gain_update_o, 1'b1);
    over_full_scale_i = 1'b0;
    pulse(limiter_step_i);
    chk("lim_wait", gain_update_o, 1'b0);
    pulse(zero_cross_i);
    chk("lim_zc", gain_update_o, 1'b1);
    foreach (ma[i]) begin
      w(ma[i], 8'hff);
      r(ma[i], mx[i]);
    end
    power_down_pin_n_i = 1'b0;
    cyc(1);
    power_down_pin_n_i = 1'b1;
    cyc(2);
    chk("pd_vol", {in_vol_o, out_vol_o}, 32'he1e19191);
    chk("pd_fmt", cfg_o.serial_format_sel, 2'b10);
    w(7'h0e, 8'h91);
    r(7'h11, 8'h01);
    finish_test();
  end
endmodule : cmr_regs_test
`default_nettype wire
